/* File: hdl/rx_pack_pkg.sv */
// Purpose: constants, register map and carrier types of the serial receive packetizer
// Assumes: 100 MHz clk_sys, APB slave with 32-bit data
// Notes: one millisecond tick drives every timer
//
// Functional notes
// - length limit 1..1024 closes a frame once occupancy reaches it
// - length limit zero adds no length trigger
// - no markers configured: every byte leaves at once, unbuffered
// - markers set: hold bytes until marker or marker pair, then send
// - second marker zero means single marker; both zero disable matching
// - full 1K buffer without marker sends and clears the buffer
// - with both markers, only the full pair triggers; needs first marker
// - pass-through option sends buffer including marker on recognition
// - plus-one or plus-two option waits one or two further bytes
// - strip option removes marker bytes, sends the rest
// - idle flush 1..65535 ms without new byte closes frame; zero disables
// - serial idle timeout closes session after no serial traffic
// - network idle check 1..99 minutes closes session; default 7, zero off
// - serial idle disabled: probe remote periodically, close on no answer
// - host commands ignored unless acceptance enabled; newest one wins
// - acceptance applies only when connection limit above one
// - listen port 1..65535, default 4001
// - serial idle timeout acts only when session opens on any character
package rx_pack_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_PER_MIN = 60000;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int BUF_BYTES = 1024;
  localparam logic [10:0] FLUSH_LEN_RST = 11'h000;
  localparam logic [6:0] NET_IDLE_RST = 7'h07;
  localparam logic [15:0] LISTEN_PORT_RST = 16'h0fa1;
  localparam logic [2:0] MAX_CONN_RST = 3'h1;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MARK = 8'h04;
  localparam logic [7:0] OFS_FLUSH = 8'h08;
  localparam logic [7:0] OFS_IDLE = 8'h0c;
  localparam logic [7:0] OFS_PORT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_HCMD = 8'h18;

  // ctrl field positions
  localparam int CTRL_PROC_LSB = 0;
  localparam int CTRL_HOST_EN = 2;
  localparam int CTRL_ANY_CHAR = 3;
  localparam int CTRL_MAXC_LSB = 4;
  localparam int CTRL_NET_LSB = 8;

  typedef enum logic [1:0] {
    PROC_PASS = 2'b00,
    PROC_PLUS1 = 2'b01,
    PROC_PLUS2 = 2'b10,
    PROC_STRIP = 2'b11
  } proc_type;

  typedef enum logic [1:0] {
    ST_FILL = 2'b00,
    ST_TAIL = 2'b01,
    ST_DRAIN = 2'b10
  } pk_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } byte_beat_type;

  typedef struct packed {
    logic [7:0] mark1;
    logic [7:0] mark2;
    proc_type proc;
    logic [10:0] flush_len;
    logic [15:0] flush_ms;
  } pack_cfg_type;

endpackage : rx_pack_pkg

/* File: hdl/ms_idle_timer.sv */
// Purpose: millisecond idle timer, restarted by activity, fires on limit
// Assumes: tick is a one-cycle pulse per millisecond
// Notes: limit zero disables; fire is a one-cycle pulse
`timescale 1ns/1ns
module ms_idle_timer #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tick,
  input wire logic restart,
  input wire logic arm,
  input wire logic [W-1:0] limit,
  output logic fire
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
    logic fire;
  } tmr_type;
  tmr_type s_r, s_nxt;

  initial
  begin
    if (W < 1 || W > 32) $error("ms_idle_timer width out of range");
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fire = 1'b0;
    if (restart || !arm || limit == '0)
    begin
      s_nxt.cnt = '0;
      s_nxt.done = 1'b0;
    end
    else if (tick && !s_r.done)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_r.cnt + 1'b1 == limit)
      begin
        s_nxt.fire = 1'b1;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign fire = s_r.fire;
endmodule : ms_idle_timer

/* File: hdl/frame_buffer.sv */
// Purpose: byte store of the packetizer with write, drop-tail and drain
// Assumes: drain only when no write is offered in the same cycle
// Notes: rd_data is registered; one byte per cycle
`timescale 1ns/1ns
module frame_buffer #(
  parameter int DEPTH = 1024
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] drop,
  input wire logic rd_en,
  input wire logic clear,
  output logic [7:0] rd_data,
  output logic [$clog2(DEPTH):0] count,
  output logic [$clog2(DEPTH):0] rd_ptr
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  typedef struct packed {
    logic [AW:0] cnt;
    logic [AW:0] rp;
    logic [7:0] rd;
  } fb_type;
  fb_type s_r, s_nxt;

  initial
  begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) $error("frame_buffer depth must be a power of two");
  end

  always_comb
  begin
    s_nxt = s_r;
    if (clear)
    begin
      s_nxt.cnt = '0;
      s_nxt.rp = '0;
    end
    else
    begin
      if (wr_en && s_r.cnt < (AW+1)'(DEPTH))
        s_nxt.cnt = s_r.cnt + 1'b1;
      if (drop != 2'b00)
        s_nxt.cnt = s_nxt.cnt - {{(AW-1){1'b0}}, drop};
      if (rd_en)
      begin
        s_nxt.rd = mem[s_r.rp[AW-1:0]];
        s_nxt.rp = s_r.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (ce && wr_en && !clear && s_r.cnt < (AW+1)'(DEPTH))
      mem[s_r.cnt[AW-1:0]] <= wr_data;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign rd_data = s_r.rd;
  assign count = s_r.cnt;
  assign rd_ptr = s_r.rp;
endmodule : frame_buffer

/* File: hdl/serial_rx_packetizer.sv */
// Purpose: packs received serial bytes into frames, runs session idle timers
// Assumes: rx bytes are one-cycle strobes, far slower than the drain
// Notes: bytes arriving while a frame drains are dropped and counted
`timescale 1ns/1ns
module serial_rx_packetizer
  import rx_pack_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_BYTES,
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int PROBE_MS = 60000,
  parameter int PROBE_WAIT_MS = 5000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_activity,
  input wire logic net_activity,
  input wire logic probe_ack,
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_cmd,
  output byte_beat_type frame_out,
  output logic probe_req,
  output logic session_close,
  output logic [7:0] ctrl_cmd,
  output logic ctrl_cmd_valid
);
  localparam int AW = $clog2(BUF_DEPTH);

  initial
  begin
    if (BUF_DEPTH < 4 || BUF_DEPTH > BUF_BYTES) $error("buffer depth out of range");
    if (TICK_DIV < 2 || PROBE_MS < 1 || PROBE_WAIT_MS < 1) $error("bad timing parameter");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pack_cfg_type cfg;
    logic host_en;
    logic any_char;
    logic [2:0] max_conn;
    logic [6:0] net_min;
    logic [15:0] idle_ms;
    logic [15:0] port;
    pk_state_type st;
    logic [1:0] tail;
    logic prev_m1;
    logic [AW:0] dlen;
    logic drd;
    logic [15:0] drops;
    logic [15:0] frames;
    logic [31:0] tick_cnt;
    logic tick;
    logic [31:0] net_ms;
    logic [31:0] probe_ms;
    logic probe_wait;
    logic probe_req;
    logic close;
    byte_beat_type out;
    logic [7:0] cmd;
    logic cmd_v;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_type;
  top_type s_r, s_nxt;

  logic [7:0] fb_rd;
  logic [AW:0] fb_cnt, fb_rp;
  logic fb_wr, fb_rd_en, fb_clr, flush_fire, sidle_fire;
  logic [1:0] fb_drop;
  logic mark_on, pair, hit, close_frame, byte_in;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  frame_buffer #(.DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wr_en(fb_wr), .wr_data(rx_data),
    .drop(fb_drop), .rd_en(fb_rd_en), .clear(fb_clr), .rd_data(fb_rd),
    .count(fb_cnt), .rd_ptr(fb_rp)
  );

  ms_idle_timer #(.W(16)) u_flush (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .tick(s_r.tick),
    .restart(rx_valid), .arm(fb_cnt != '0 && s_r.st != ST_DRAIN),
    .limit(s_r.cfg.flush_ms), .fire(flush_fire)
  );

  ms_idle_timer #(.W(16)) u_sidle (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .tick(s_r.tick),
    .restart(rx_valid || tx_activity), .arm(s_r.any_char),
    .limit(s_r.idle_ms), .fire(sidle_fire)
  );

  assign byte_in = rx_valid && s_r.st == ST_FILL && mark_on;
  assign mark_on = s_r.cfg.mark1 != 8'h00;
  assign pair = s_r.cfg.mark2 != 8'h00;
  // single marker, or second marker right after the first one
  assign hit = byte_in && (pair ? (s_r.prev_m1 && rx_data == s_r.cfg.mark2)
                                : rx_data == s_r.cfg.mark1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.out = '0;
    s_nxt.cmd_v = 1'b0;
    s_nxt.close = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.probe_req = 1'b0;
    fb_wr = 1'b0;
    fb_drop = 2'b00;
    fb_rd_en = 1'b0;
    fb_clr = 1'b0;
    close_frame = 1'b0;

    // millisecond tick
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == 32'(TICK_DIV - 1))
    begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;

    // packing
    case (s_r.st)
      ST_FILL:
      begin
        if (rx_valid && !mark_on)
        begin
          s_nxt.out = '{valid: 1'b1, data: rx_data, last: 1'b1};
          s_nxt.frames = s_r.frames + 1'b1;
        end
        else if (byte_in)
        begin
          fb_wr = 1'b1;
          s_nxt.prev_m1 = rx_data == s_r.cfg.mark1;
          if (hit)
          begin
            case (s_r.cfg.proc)
              PROC_PASS: close_frame = 1'b1;
              PROC_STRIP:
              begin
                fb_drop = pair ? 2'd2 : 2'd1;
                close_frame = 1'b1;
              end
              PROC_PLUS1:
              begin
                s_nxt.tail = 2'd1;
                s_nxt.st = ST_TAIL;
              end
              default:
              begin
                s_nxt.tail = 2'd2;
                s_nxt.st = ST_TAIL;
              end
            endcase
          end
          if (s_r.cfg.flush_len != '0 && fb_cnt + 1'b1 >= s_r.cfg.flush_len)
            close_frame = 1'b1;
          if (fb_cnt + 1'b1 == (AW+1)'(BUF_DEPTH))
            close_frame = 1'b1;
          if (close_frame)
            s_nxt.st = ST_DRAIN;
        end
        else if (flush_fire && fb_cnt != '0)
          s_nxt.st = ST_DRAIN;
        if (s_nxt.st == ST_DRAIN)
          s_nxt.prev_m1 = 1'b0;
      end
      ST_TAIL:
      begin
        if (rx_valid)
        begin
          fb_wr = 1'b1;
          if (s_r.tail == 2'd1 || fb_cnt + 1'b1 == (AW+1)'(BUF_DEPTH))
            s_nxt.st = ST_DRAIN;
          else
            s_nxt.tail = s_r.tail - 1'b1;
        end
        else if (flush_fire)
          s_nxt.st = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        if (rx_valid)
          s_nxt.drops = s_r.drops + 1'b1;
        // stripping may empty the buffer, so a frame can be zero long
        if (!s_r.drd && fb_rp >= fb_cnt)
        begin
          fb_clr = 1'b1;
          s_nxt.st = ST_FILL;
          if (fb_cnt != '0)
            s_nxt.frames = s_r.frames + 1'b1;
        end
        else if (!s_r.drd)
        begin
          fb_rd_en = 1'b1;
          s_nxt.drd = 1'b1;
        end
        else
        begin
          s_nxt.drd = 1'b0;
          s_nxt.out = '{valid: 1'b1, data: fb_rd, last: fb_rp == fb_cnt};
        end
      end
      default: s_nxt.st = ST_FILL;
    endcase

    // session timers
    if (net_activity || s_r.net_min == '0)
      s_nxt.net_ms = '0;
    else if (s_r.tick)
    begin
      s_nxt.net_ms = s_r.net_ms + 1'b1;
      if (s_r.net_ms + 1'b1 == 32'(s_r.net_min) * 32'(MS_PER_MIN))
        s_nxt.close = 1'b1;
    end
    if (sidle_fire)
      s_nxt.close = 1'b1;

    if (s_r.any_char && s_r.idle_ms != '0)
    begin
      s_nxt.probe_ms = '0;
      s_nxt.probe_wait = 1'b0;
    end
    else
    begin
      if (s_r.probe_wait && probe_ack)
      begin
        s_nxt.probe_wait = 1'b0;
        s_nxt.probe_ms = '0;
      end
      else if (s_r.tick)
      begin
        s_nxt.probe_ms = s_r.probe_ms + 1'b1;
        if (!s_r.probe_wait && s_r.probe_ms + 1'b1 == 32'(PROBE_MS))
        begin
          s_nxt.probe_req = 1'b1;
          s_nxt.probe_wait = 1'b1;
          s_nxt.probe_ms = '0;
        end
        else if (s_r.probe_wait && s_r.probe_ms + 1'b1 == 32'(PROBE_WAIT_MS))
        begin
          s_nxt.close = 1'b1;
          s_nxt.probe_wait = 1'b0;
          s_nxt.probe_ms = '0;
        end
      end
    end

    // host control commands; a later one simply overwrites
    if (host_cmd_valid && (s_r.max_conn <= 3'd1 || s_r.host_en))
    begin
      s_nxt.cmd = host_cmd;
      s_nxt.cmd_v = 1'b1;
    end

    // apb slave, answers one cycle after the access cycle starts (one wait state)
    if (psel && penable && !s_r.pready)
    begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = '0;
      if (paddr == OFS_CTRL)
      begin
        s_nxt.prdata = {17'h0, s_r.net_min, 1'b0, s_r.max_conn,
                        s_r.any_char, s_r.host_en, s_r.cfg.proc};
        if (pwrite)
        begin
          s_nxt.cfg.proc = proc_type'(pwdata[CTRL_PROC_LSB +: 2]);
          s_nxt.host_en = pwdata[CTRL_HOST_EN];
          s_nxt.any_char = pwdata[CTRL_ANY_CHAR];
          s_nxt.max_conn = pwdata[CTRL_MAXC_LSB +: 3];
          s_nxt.net_min = pwdata[CTRL_NET_LSB +: 7] > 7'd99 ? 7'd99 : pwdata[CTRL_NET_LSB +: 7];
        end
      end
      else if (paddr == OFS_MARK)
      begin
        s_nxt.prdata = {16'h0, s_r.cfg.mark2, s_r.cfg.mark1};
        if (pwrite)
        begin
          s_nxt.cfg.mark1 = pwdata[7:0];
          s_nxt.cfg.mark2 = pwdata[15:8];
        end
      end
      else if (paddr == OFS_FLUSH)
      begin
        s_nxt.prdata = {5'h0, s_r.cfg.flush_len, s_r.cfg.flush_ms};
        if (pwrite)
        begin
          s_nxt.cfg.flush_ms = pwdata[15:0];
          s_nxt.cfg.flush_len = pwdata[26:16] > 11'd1024 ? 11'd1024 : pwdata[26:16];
        end
      end
      else if (paddr == OFS_IDLE)
      begin
        s_nxt.prdata = {16'h0, s_r.idle_ms};
        if (pwrite)
          s_nxt.idle_ms = pwdata[15:0];
      end
      else if (paddr == OFS_PORT)
      begin
        s_nxt.prdata = {16'h0, s_r.port};
        if (pwrite && pwdata[15:0] != 16'h0000)
          s_nxt.port = pwdata[15:0];
      end
      else if (paddr == OFS_STAT)
        s_nxt.prdata = {s_r.drops, s_r.frames};
      else if (paddr == OFS_HCMD)
        s_nxt.prdata = 32'(fb_cnt);
      else
        s_nxt.pslverr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.cfg.flush_len <= FLUSH_LEN_RST;
      s_r.net_min <= NET_IDLE_RST;
      s_r.port <= LISTEN_PORT_RST;
      s_r.max_conn <= MAX_CONN_RST;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign frame_out = s_r.out;
  assign probe_req = s_r.probe_req;
  assign session_close = s_r.close;
  assign ctrl_cmd = s_r.cmd;
  assign ctrl_cmd_valid = s_r.cmd_v;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
endmodule : serial_rx_packetizer

/* File: tb/rx_pack_asserts.sv */
// Purpose: port checks of serial_rx_packetizer
// Assumes: config shadow follows APB writes at the taken edge
// Notes: sees only top ports; probe wait counts enabled cycles only
`timescale 1ns/1ns
module rx_pack_asserts
  import rx_pack_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int PROBE_WAIT_MS = 5000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic probe_ack,
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_cmd,
  input wire byte_beat_type frame_out,
  input wire logic probe_req,
  input wire logic session_close,
  input wire logic [7:0] ctrl_cmd,
  input wire logic ctrl_cmd_valid
);
  // ----------------------------------------
  // shadow of config, probe wait counter
  // ----------------------------------------
  localparam int PW_MAX = (PROBE_WAIT_MS + 1) * TICK_DIV + 4;
  logic [15:0] mark_r;
  logic [6:0] ctl_r;
  int pw_r;
  wire take = psel && penable && !pready && pwrite;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mark_r <= 16'h0000;
      ctl_r <= 7'h10;
      pw_r <= 0;
    end
    else
    begin
      if (take && paddr == OFS_MARK)
        mark_r <= pwdata[15:0];
      if (take && paddr == OFS_CTRL)
        ctl_r <= pwdata[6:0];
      if (probe_req)
        pw_r <= 1;
      else if (probe_ack || session_close)
        pw_r <= 0;
      else if (pw_r != 0 && ce)
        pw_r <= pw_r + 1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_beat;
    frame_out.valid && !frame_out.last;
  endsequence
  sequence s_gap;
    !frame_out.valid ##1 frame_out.valid;
  endsequence
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reset_quiet: assert property ($rose(rstn) |-> !frame_out.valid && !session_close)
    else $error("output active after reset");
  a_nomark_fwd: assert property (ce && rx_valid && mark_r == 16'h0000 |=>
    frame_out.valid && frame_out.last && frame_out.data == $past(rx_data))
    else $error("byte not forwarded at once");
  a_host_block: assert property (host_cmd_valid && ctl_r[6:4] > 3'h1 && !ctl_r[2]
    |=> !ctrl_cmd_valid)
    else $error("host command passed while blocked");
  a_host_take: assert property (host_cmd_valid && (ctl_r[6:4] <= 3'h1 || ctl_r[2])
    |=> ctrl_cmd_valid && ctrl_cmd == $past(host_cmd))
    else $error("host command lost");
  a_strip_clean: assert property (frame_out.valid && ctl_r[1:0] == PROC_STRIP
    && mark_r[7:0] != 8'h00 && mark_r[15:8] == 8'h00 |-> frame_out.data != mark_r[7:0])
    else $error("marker left in stripped frame");
  a_beat_gap: assert property (s_beat |=> s_gap)
    else $error("frame beats not evenly spaced");
  a_probe_close: assert property (pw_r <= PW_MAX)
    else $error("unanswered probe did not close session");
endmodule : rx_pack_asserts

/* File: tb/remote_peer.sv */
// Purpose: network side of the packetizer: takes frames, answers probes
// Assumes: frame beats are one-cycle pulses
// Notes: ack_on low leaves probes unanswered; ack_dly sets answer delay
`timescale 1ns/1ns
module remote_peer
  import rx_pack_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire byte_beat_type frame_out,
  input wire logic probe_req,
  input wire logic ack_on,
  input wire logic [2:0] ack_dly,
  output logic probe_ack
);
  logic [7:0] got[$];
  int n_frames = 0;
  int wait_r = 0;
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      probe_ack <= 1'b0;
      wait_r = 0;
    end
    else
    begin
      probe_ack <= 1'b0;
      if (frame_out.valid)
      begin
        got.push_back(frame_out.data);
        n_frames += frame_out.last;
      end
      if (probe_req && ack_on)
        wait_r = ack_dly + 1;
      else if (wait_r == 1)
      begin
        probe_ack <= 1'b1;
        wait_r = 0;
      end
      else if (wait_r > 1)
        wait_r--;
    end
  end
endmodule : remote_peer

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of serial_rx_packetizer
// Assumes: 10-cycle ms tick, 16-byte buffer in simulation
// Notes: expected frames are built by the bench as bytes are sent
`timescale 1ns/1ns
module tb_top
  import rx_pack_pkg::*;
;
  localparam int TD = 10;
  localparam int DEP = 16;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic host_cmd_valid = 1'b0;
  logic [7:0] host_cmd = 8'h00;
  logic ack_on = 1'b1;
  logic [2:0] ack_dly = 3'h0;
  logic ce_on = 1'b1;
  logic tx_act = 1'b0;
  logic probe_ack;
  byte_beat_type frame_out;
  logic probe_req;
  logic session_close;
  logic [7:0] ctrl_cmd;
  logic ctrl_cmd_valid;
  logic [31:0] rng = 32'd36931;
  logic [31:0] q_v;
  logic err_v;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  int n_close = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (session_close === 1'b1)
      n_close++;
  serial_rx_packetizer #(.BUF_DEPTH(DEP), .TICK_DIV(TD), .PROBE_MS(5), .PROBE_WAIT_MS(3))
    serial_rx_packetizer_i (.clk_sys, .rstn, .ce(ce_on), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .tx_activity(tx_act),
    .net_activity(1'b0), .probe_ack, .host_cmd_valid, .host_cmd, .frame_out, .probe_req,
    .session_close, .ctrl_cmd, .ctrl_cmd_valid);
  remote_peer remote_peer_i (.clk_sys, .rstn, .frame_out, .probe_req, .ack_on, .ack_dly,
    .probe_ack);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd
  function automatic int tail_len(input int m);
    return (m == 1) ? 1 : (m == 2) ? 2 : 0;
  endfunction : tail_len
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h00000000);
    chk("prdata", e, q_v);
    chk("pslverr", {31'h0, ee}, {31'h0, err_v});
  endtask : rd
  task automatic send(input logic [7:0] b, input int gap);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    tick(gap);
  endtask : send
  // random payload byte, never a marker value
  task automatic send_rand(input int gap);
    logic [31:0] r;
    r = rnd();
    if (r[7:0] == 8'h0d || r[7:0] == 8'h0a)
      r[7:0] = 8'h41;
    exp_q.push_back(r[7:0]);
    send(r[7:0], gap);
  endtask : send_rand
  task automatic chk_frames(input int n);
    int k;
    k = 0;
    while (remote_peer_i.n_frames < n && k < 600)
    begin
      @(posedge clk_sys);
      k++;
    end
    tick(6);
    chk("frames", n, remote_peer_i.n_frames);
    chk("bytes", exp_q.size(), remote_peer_i.got.size());
    foreach (exp_q[i])
      if (i < remote_peer_i.got.size())
        chk("byte", {24'h0, exp_q[i]}, {24'h0, remote_peer_i.got[i]});
    exp_q.delete();
    remote_peer_i.got.delete();
    remote_peer_i.n_frames = 0;
  endtask : chk_frames
  task automatic host(input logic [7:0] c1, input logic [7:0] c2, input logic ev);
    host_cmd_valid <= 1'b1;
    host_cmd <= c1;
    @(posedge clk_sys);
    host_cmd <= c2;
    @(posedge clk_sys);
    host_cmd_valid <= 1'b0;
    @(negedge clk_sys);
    chk("cmd_valid", {31'h0, ev}, {31'h0, ctrl_cmd_valid});
    if (ev)
      chk("cmd", {24'h0, c2}, {24'h0, ctrl_cmd});
    @(posedge clk_sys);
  endtask : host
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  logic [31:0] host_cfg[4] = '{32'h00000710, 32'h00000720, 32'h00000724, 32'h00000714};
  logic host_ev[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0] pair_seq[6] = '{8'h41, 8'h0d, 8'h42, 8'h0a, 8'h0d, 8'h0a};
  initial
  begin
    int n;
    int k;
    logic [31:0] r;
    tick(12);
    rstn <= 1'b1;
    tick(1);
    rd(OFS_CTRL, 32'h00000710, 1'b0);
    rd(OFS_MARK, 32'h00000000, 1'b0);
    rd(OFS_FLUSH, 32'h00000000, 1'b0);
    rd(OFS_IDLE, 32'h00000000, 1'b0);
    rd(OFS_PORT, 32'h00000fa1, 1'b0);
    rd(8'h1c, 32'h00000000, 1'b1);
    wr(OFS_PORT, 32'h00000000);
    rd(OFS_PORT, 32'h00000fa1, 1'b0);
    wr(OFS_PORT, 32'h0000ffff);
    rd(OFS_PORT, 32'h0000ffff, 1'b0);
    wr(OFS_CTRL, 32'h00007f10);
    rd(OFS_CTRL, 32'h00006310, 1'b0);
    wr(OFS_MARK, 32'h0000000d);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_CTRL, 32'h00000710 | m);
      r = rnd();
      ack_dly <= r[2:0];
      n = 1 + int'(r[10:8] % 5);
      repeat (n) send_rand(3);
      send(8'h0d, 3);
      if (m != 3)
        exp_q.push_back(8'h0d);
      tick(12);
      if (tail_len(m) > 0)
        chk("held", 0, remote_peer_i.n_frames);
      repeat (tail_len(m)) send_rand(3);
      chk_frames(1);
    end
    wr(OFS_CTRL, 32'h00000710);
    wr(OFS_MARK, 32'h00000a0d);
    foreach (pair_seq[i])
    begin
      exp_q.push_back(pair_seq[i]);
      send(pair_seq[i], 3);
    end
    chk_frames(1);
    wr(OFS_MARK, 32'h0000000d);
    wr(OFS_FLUSH, 32'h00040000);
    repeat (4) send_rand(3);
    chk_frames(1);
    wr(OFS_FLUSH, 32'h00000000);
    repeat (DEP) send_rand(2);
    chk_frames(1);
    wr(OFS_FLUSH, 32'h00000003);
    send_rand(15);
    send_rand(15);
    chk("early", 0, remote_peer_i.n_frames);
    chk_frames(1);
    wr(OFS_FLUSH, 32'h00000000);
    wr(OFS_MARK, 32'h00000000);
    ce_on <= 1'b0;
    send(8'h5a, 20);
    ce_on <= 1'b1;
    repeat (3) send_rand(2);
    chk_frames(3);
    rd(OFS_STAT, 32'h0000000b, 1'b0);
    foreach (host_cfg[i])
    begin
      wr(OFS_CTRL, host_cfg[i]);
      r = rnd();
      host(r[7:0], r[15:8], host_ev[i]);
    end
    wr(OFS_IDLE, 32'h00000002);
    wr(OFS_CTRL, 32'h00000710);
    k = n_close;
    tick(60);
    chk("close", k, n_close);
    wr(OFS_CTRL, 32'h00000718);
    k = n_close;
    tx_act <= 1'b1;
    tick(48);
    chk("tx_restart", k, n_close);
    tx_act <= 1'b0;
    tick(40);
    chk("close_seen", 1, {31'h0, n_close > k});
    wr(OFS_CTRL, 32'h00000710);
    wr(OFS_IDLE, 32'h00000000);
    ack_on <= 1'b0;
    k = n_close;
    tick(120);
    chk("probe_close", 1, {31'h0, n_close > k});
    close_out();
  end
  initial
  begin
    tick(20000);
    n_fail++;
    $display("unexpected watchdog expected finish seen hang");
    close_out();
  end
endmodule : tb_top

bind serial_rx_packetizer rx_pack_asserts #(.TICK_DIV(TICK_DIV), .PROBE_WAIT_MS(PROBE_WAIT_MS))
  rx_pack_asserts_i (.clk_sys, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .rx_valid, .rx_data, .probe_ack, .host_cmd_valid, .host_cmd, .frame_out,
  .probe_req, .session_close, .ctrl_cmd, .ctrl_cmd_valid);
